// File: src/adcseq_params.svh
/*
  Constants of the serial converter sequencer: bit positions of the control
  byte, reset values and timing counts.
  Assumes it is included by its bare name wherever the constants are needed.
*/
`ifndef ADCSEQ_PARAMS_SVH
`define ADCSEQ_PARAMS_SVH

// Control byte layout, start bit at position 7
`define ADCSEQ_BYTE_BITS 8
`define ADCSEQ_POS_POLARITY 6
`define ADCSEQ_POS_CLKSRC 5
`define ADCSEQ_POS_MODE_HI 4
`define ADCSEQ_POS_MODE_LO 3

// Acquisition and conversion framing, in serial clocks
`define ADCSEQ_ACQ_START_FALL 1
`define ADCSEQ_SHORT_SAMPLE_FALL 6
`define ADCSEQ_LONG_EXTRA 8
`define ADCSEQ_SHORT_ACQ_CYCLES 5
`define ADCSEQ_LONG_ACQ_CYCLES 13
`define ADCSEQ_SHORT_PERIOD 24
`define ADCSEQ_LONG_PERIOD 32
`define ADCSEQ_RANGE_PENALTY_HALF 3

// Calibration length in conversion clock cycles
`define ADCSEQ_CAL_CYCLES 80000

// Internal clock conversion time
`define ADCSEQ_CLK_PERIOD_NS 100
`define ADCSEQ_CONV_TIME_NS 7000

// Reset values
`define ADCSEQ_RST_UNIPOLAR 1'b0
`define ADCSEQ_RST_INTERNAL 1'b1
`define ADCSEQ_RST_LONG 1'b0
`define ADCSEQ_RST_USER 3'h0
`define ADCSEQ_RST_RESULT 16'h0000
// Synchroniser idle: {hard_reset_n, shutdown_n, din, cs_n, sclk}
`define ADCSEQ_RST_PINS 5'h1a

`endif

// File: src/adcseq_pkg.sv
/*
  Types of the serial converter sequencer: modes, states and the state
  record of the core.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adcseq_pkg;

  typedef enum logic [1:0] {MODE_SHORT, MODE_CAL, MODE_SHUTDOWN_N, MODE_LONG} adcseq_mode_type;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_CONV, ST_CAL} adcseq_fsm_type;

  typedef struct packed {
    adcseq_fsm_type state;
    adcseq_mode_type mode;
    logic sclk_d;
    logic [2:0] bit_cnt;
    logic [5:0] fall_cnt;
    logic mode_hi;
    logic mode_lo;
    logic clk_bit;
    logic [2:0] user_sh;
    logic [2:0] user;
    logic unipolar;
    logic internal;
    logic long_acq;
    logic changed;
    logic rearm;
    logic acquire;
    logic [4:0] acq_half;
    logic [4:0] acq_len;
    logic strobe;
    logic strobe_oe;
    logic [16:0] cnt;
    logic pd;
    logic pd_out;
    logic load;
    logic cal_flag;
    logic conv_flag;
  } adcseq_core_state_type;

endpackage : adcseq_pkg

// File: src/adcseq_sync.sv
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/1ns
module adcseq_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } adcseq_sync_state_type;

  adcseq_sync_state_type s_r;
  adcseq_sync_state_type s_nxt;

  always_comb
  begin
    s_nxt.meta = async_in;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= {RESET_VALUE, RESET_VALUE};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.stable;

endmodule : adcseq_sync

// File: src/adcseq_shift_out.sv
/*
  Result output shifter: loads a finished result and shifts it out MSB first
  on serial clock falling edges while chip select is low.
  Assumes edge and select inputs are already synchronous to clk_in.
*/
`timescale 1ns/1ns
`include "adcseq_params.svh"
module adcseq_shift_out #(
  parameter int WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic fall_in,
  input wire logic cs_n_in,
  output logic dout_out,
  output logic dout_oe_out
);

  typedef struct packed {
    logic [WIDTH-1:0] sh;
    logic dout;
    logic oe;
  } adcseq_shift_state_type;

  adcseq_shift_state_type s_r;
  adcseq_shift_state_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.oe = ~cs_n_in;
    if (load_in)
    begin
      s_nxt.dout = data_in[WIDTH-1];
      s_nxt.sh = {data_in[WIDTH-2:0], 1'b0};
    end
    else if (fall_in && !cs_n_in)
    begin
      // Result leaves while the next control byte arrives
      s_nxt.dout = s_r.sh[WIDTH-1];
      s_nxt.sh = {s_r.sh[WIDTH-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign dout_out = s_r.dout;
  assign dout_oe_out = s_r.oe;

endmodule : adcseq_shift_out

// File: src/adcseq_core.sv
/*
  Conversion sequencer of a serial successive-approximation converter:
  control byte reception, mode decode, acquisition timing, conversion and
  calibration strobe, software and hardware shutdown.
  Assumes pins arrive asynchronously and the serial clock is far slower than
  clk_in; result_in comes from the converter array on clk_in.
*/
// Behaviour
// - Mode 01 starts calibration
// - Internal clock: strobe low, high after count
// - External clock: strobe high, low at end
// - Polarity bit picks unipolar or bipolar range
// - Start bit starts acquisition in previous range
// - Second bit switches range at once
// - Range change shortens acquisition by 1.5 clocks
// - Mode 11 adds eight acquisition clocks
// - Short mode samples on sixth falling edge
// - Mode 00: five clock acquisition, 24 clocks
// - Long mode: thirteen clock acquisition, 32 clocks
// - Every byte transfer is full duplex
// - First one after select or completion starts
// - Mode 10 powers down after conversion
// - Reset, shutdown or restart aborts calibration
// - Bit five selects internal or serial clock
`timescale 1ns/1ns
`include "adcseq_params.svh"
module adcseq_core #(
  parameter int CAL_CYCLES = `ADCSEQ_CAL_CYCLES,
  parameter int CONV_CYCLES = `ADCSEQ_CONV_TIME_NS / `ADCSEQ_CLK_PERIOD_NS,
  parameter int RESULT_WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  input wire logic shutdown_n_in,
  input wire logic hard_reset_n_in,
  input wire logic [RESULT_WIDTH-1:0] result_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic conversion_strobe_out,
  output logic conversion_strobe_oe_out,
  output logic [2:0] user_out,
  output logic input_polarity_select_out,
  output logic clock_source_select_out,
  output logic acquire_out,
  output logic [4:0] acq_len_out,
  output logic powered_down_out,
  output logic calibrating_out,
  output logic converting_out
);

  localparam logic [2:0] IDX_POL = 3'(`ADCSEQ_BYTE_BITS - 1 - `ADCSEQ_POS_POLARITY);
  localparam logic [2:0] IDX_CLK = 3'(`ADCSEQ_BYTE_BITS - 1 - `ADCSEQ_POS_CLKSRC);
  localparam logic [2:0] IDX_HI = 3'(`ADCSEQ_BYTE_BITS - 1 - `ADCSEQ_POS_MODE_HI);
  localparam logic [2:0] IDX_LO = 3'(`ADCSEQ_BYTE_BITS - 1 - `ADCSEQ_POS_MODE_LO);
  localparam logic [2:0] IDX_LAST = 3'(`ADCSEQ_BYTE_BITS - 1);
  localparam logic [5:0] FALL_ACQ = 6'(`ADCSEQ_ACQ_START_FALL);
  localparam logic [5:0] FALL_SHORT = 6'(`ADCSEQ_SHORT_SAMPLE_FALL);
  localparam logic [5:0] FALL_LONG = 6'(`ADCSEQ_SHORT_SAMPLE_FALL + `ADCSEQ_LONG_EXTRA);
  localparam logic [5:0] PERIOD_SHORT = 6'(`ADCSEQ_SHORT_PERIOD);
  localparam logic [5:0] PERIOD_LONG = 6'(`ADCSEQ_LONG_PERIOD);
  localparam logic [4:0] HALF_SHORT = 5'(2 * `ADCSEQ_SHORT_ACQ_CYCLES);
  localparam logic [4:0] HALF_LONG = 5'(2 * `ADCSEQ_LONG_ACQ_CYCLES);
  localparam logic [4:0] HALF_PENALTY = 5'(`ADCSEQ_RANGE_PENALTY_HALF);
  localparam logic [16:0] CAL_LAST = 17'(CAL_CYCLES - 1);
  localparam logic [16:0] CONV_LAST = 17'(CONV_CYCLES - 1);

  // Mode field to operation
  function automatic adcseq_pkg::adcseq_mode_type adcseq_decode(input logic hi, input logic lo);
    adcseq_pkg::adcseq_mode_type m;
    case ({hi, lo})
      2'b00: m = adcseq_pkg::MODE_SHORT;
      2'b01: m = adcseq_pkg::MODE_CAL;
      2'b10: m = adcseq_pkg::MODE_SHUTDOWN_N;
      default: m = adcseq_pkg::MODE_LONG;
    endcase
    return m;
  endfunction : adcseq_decode

  // Shutdown conversions keep the previous acquisition length
  function automatic logic adcseq_pick_long(input adcseq_pkg::adcseq_mode_type m,
                                            input logic prev);
    return (m == adcseq_pkg::MODE_LONG) || ((m == adcseq_pkg::MODE_SHUTDOWN_N) && prev);
  endfunction : adcseq_pick_long

  function automatic adcseq_pkg::adcseq_core_state_type adcseq_reset_state();
    adcseq_pkg::adcseq_core_state_type r;
    r = '0;
    r.state = adcseq_pkg::ST_IDLE;
    r.mode = adcseq_pkg::MODE_SHORT;
    r.user = `ADCSEQ_RST_USER;
    r.unipolar = `ADCSEQ_RST_UNIPOLAR;
    r.internal = `ADCSEQ_RST_INTERNAL;
    r.long_acq = `ADCSEQ_RST_LONG;
    r.strobe = `ADCSEQ_RST_INTERNAL;
    r.strobe_oe = 1'b1;
    return r;
  endfunction : adcseq_reset_state

  localparam adcseq_pkg::adcseq_core_state_type RST_STATE = adcseq_reset_state();

  adcseq_pkg::adcseq_core_state_type s_r;
  adcseq_pkg::adcseq_core_state_type s_nxt;

  logic [4:0] pins_s;
  logic sclk_s;
  logic cs_s;
  logic din_s;
  logic shutdown_n_s;
  logic hrst_s;
  logic rise_v;
  logic fall_v;
  logic start_ok;
  logic recv;
  logic byte_done;
  logic eff_long;
  logic eff_int;
  logic sample_end;
  logic conv_done;
  logic [2:0] bit_new;
  logic [5:0] fall_new;
  logic [5:0] fall_target;
  logic [5:0] period;
  adcseq_pkg::adcseq_mode_type mode_new;

  adcseq_sync #(
    .WIDTH(5),
    .RESET_VALUE(`ADCSEQ_RST_PINS)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({hard_reset_n_in, shutdown_n_in, din_in, cs_n_in, sclk_in}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_s = pins_s[1];
  assign din_s = pins_s[2];
  assign shutdown_n_s = pins_s[3];
  assign hrst_s = pins_s[4];

  // Serial clock edges count only while selected
  assign rise_v = sclk_s && !s_r.sclk_d && !cs_s;
  assign fall_v = !sclk_s && s_r.sclk_d && !cs_s;
  assign bit_new = s_r.bit_cnt + 3'h1;
  assign fall_new = s_r.fall_cnt + 6'h01;
  assign mode_new = adcseq_decode(s_r.mode_hi, s_r.mode_lo);
  assign eff_long = (s_r.bit_cnt > IDX_LO) ? adcseq_pick_long(mode_new, s_r.long_acq)
                                           : s_r.long_acq;
  assign eff_int = (s_r.bit_cnt >= IDX_CLK) ? s_r.clk_bit : s_r.internal;
  assign fall_target = eff_long ? FALL_LONG : FALL_SHORT;
  assign period = eff_long ? PERIOD_LONG : PERIOD_SHORT;
  // First one after completion, or after a select pulse when busy
  assign start_ok = rise_v && din_s && ((s_r.state == adcseq_pkg::ST_IDLE) || s_r.rearm);
  assign recv = rise_v && (s_r.bit_cnt < IDX_LAST) &&
                ((s_r.state == adcseq_pkg::ST_SHIFT) || (s_r.state == adcseq_pkg::ST_CONV));
  assign byte_done = recv && (bit_new == IDX_LAST);
  assign sample_end = fall_v && s_r.acquire && (fall_new == fall_target);
  assign conv_done = (s_r.state == adcseq_pkg::ST_CONV) &&
                     (eff_int ? (s_r.cnt == CONV_LAST) : (fall_v && (fall_new == period)));

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sclk_d = sclk_s;
    s_nxt.load = 1'b0;
    s_nxt.strobe_oe = s_r.internal | ~cs_s;
    if (cs_s)
    begin
      s_nxt.rearm = 1'b1;
    end
    if (!hrst_s)
    begin
      s_nxt = RST_STATE;
      s_nxt.sclk_d = sclk_s;
    end
    else if (!shutdown_n_s)
    begin
      // Hardware shutdown ends any operation
      s_nxt.state = adcseq_pkg::ST_IDLE;
      s_nxt.acquire = 1'b0;
      s_nxt.strobe = s_r.internal;
    end
    else if (start_ok)
    begin
      // Acquire in the previous range
      s_nxt.state = adcseq_pkg::ST_SHIFT;
      s_nxt.bit_cnt = 3'h0;
      s_nxt.fall_cnt = 6'h00;
      s_nxt.acquire = 1'b1;
      s_nxt.acq_half = 5'h00;
      s_nxt.changed = 1'b0;
      s_nxt.rearm = 1'b0;
      s_nxt.pd = 1'b0;
      s_nxt.strobe = s_r.internal;
    end
    else
    begin
      if (recv)
      begin
        s_nxt.bit_cnt = bit_new;
        if (bit_new == IDX_POL)
        begin
          if (din_s != s_r.unipolar)
          begin
            s_nxt.unipolar = din_s;
            s_nxt.changed = 1'b1;
          end
        end
        else if (bit_new == IDX_CLK)
        begin
          s_nxt.clk_bit = din_s;
        end
        else if (bit_new == IDX_HI)
        begin
          s_nxt.mode_hi = din_s;
        end
        else if (bit_new == IDX_LO)
        begin
          s_nxt.mode_lo = din_s;
        end
        else
        begin
          s_nxt.user_sh = {s_r.user_sh[1:0], din_s};
        end
      end
      if (s_r.acquire && (s_r.fall_cnt >= FALL_ACQ) && (rise_v || fall_v))
      begin
        s_nxt.acq_half = s_r.acq_half + 5'h01;
      end
      if (fall_v && (s_r.state != adcseq_pkg::ST_IDLE))
      begin
        s_nxt.fall_cnt = fall_new;
      end
      case (s_r.state)
        adcseq_pkg::ST_SHIFT:
        begin
          if (sample_end)
          begin
            s_nxt.acquire = 1'b0;
            s_nxt.acq_len = s_nxt.acq_half - (s_r.changed ? HALF_PENALTY : 5'h00);
            s_nxt.state = adcseq_pkg::ST_CONV;
            s_nxt.cnt = 17'h0_0000;
            s_nxt.strobe = 1'b0;
          end
        end
        adcseq_pkg::ST_CONV:
        begin
          if (eff_int)
          begin
            s_nxt.cnt = s_r.cnt + 17'h0_0001;
            s_nxt.strobe = 1'b0;
          end
          else if (fall_v && (fall_new == fall_target + 6'h01))
          begin
            s_nxt.strobe = 1'b1;
          end
          else if (fall_v && (fall_new == fall_target + 6'h02))
          begin
            s_nxt.strobe = 1'b0;
          end
          if (conv_done)
          begin
            s_nxt.load = 1'b1;
            s_nxt.state = adcseq_pkg::ST_IDLE;
            s_nxt.strobe = eff_int;
            s_nxt.pd = (s_r.mode == adcseq_pkg::MODE_SHUTDOWN_N);
          end
        end
        adcseq_pkg::ST_CAL:
        begin
          if (s_r.internal || fall_v)
          begin
            s_nxt.cnt = s_r.cnt + 17'h0_0001;
            if (s_r.cnt == CAL_LAST)
            begin
              s_nxt.state = adcseq_pkg::ST_IDLE;
              s_nxt.strobe = s_r.internal;
            end
          end
        end
        default:
        begin
          s_nxt.acquire = 1'b0;
        end
      endcase
      if (byte_done)
      begin
        s_nxt.mode = mode_new;
        s_nxt.user = {s_r.user_sh[1:0], din_s};
        s_nxt.internal = s_r.clk_bit;
        s_nxt.long_acq = adcseq_pick_long(mode_new, s_r.long_acq);
        if (mode_new == adcseq_pkg::MODE_CAL)
        begin
          s_nxt.state = adcseq_pkg::ST_CAL;
          s_nxt.cnt = 17'h0_0000;
          s_nxt.acquire = 1'b0;
          s_nxt.strobe = ~s_r.clk_bit;
        end
      end
    end
    s_nxt.pd_out = s_nxt.pd | ~shutdown_n_s;
    s_nxt.cal_flag = (s_nxt.state == adcseq_pkg::ST_CAL);
    s_nxt.conv_flag = (s_nxt.state == adcseq_pkg::ST_CONV);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= RST_STATE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  adcseq_shift_out #(
    .WIDTH(RESULT_WIDTH)
  ) u_shift (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(s_r.load),
    .data_in(result_in),
    .fall_in(fall_v),
    .cs_n_in(cs_s),
    .dout_out(dout_out),
    .dout_oe_out(dout_oe_out)
  );

  assign conversion_strobe_out = s_r.strobe;
  assign conversion_strobe_oe_out = s_r.strobe_oe;
  assign user_out = s_r.user;
  assign input_polarity_select_out = s_r.unipolar;
  assign clock_source_select_out = s_r.internal;
  assign acquire_out = s_r.acquire;
  assign acq_len_out = s_r.acq_len;
  assign powered_down_out = s_r.pd_out;
  assign calibrating_out = s_r.cal_flag;
  assign converting_out = s_r.conv_flag;

  // Checks
  sequence seq_quiet;
    hrst_s && shutdown_n_s && !start_ok;
  endsequence

  sequence seq_cal_request;
    seq_quiet ##0 byte_done && (mode_new == adcseq_pkg::MODE_CAL);
  endsequence

  a_cal_entry: assert property (@(posedge clk_in) disable iff (rst_in)
    seq_cal_request |=> (s_r.state == adcseq_pkg::ST_CAL) && (s_r.strobe == ~s_r.internal))
    else $error("calibration request not taken");

  a_cal_int_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_r.state == adcseq_pkg::ST_CAL) && s_r.internal |-> !conversion_strobe_out)
    else $error("strobe high during internal calibration");

  a_cal_ext_high: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_r.state == adcseq_pkg::ST_CAL) && !s_r.internal |-> conversion_strobe_out)
    else $error("strobe low during external calibration");

  a_cal_int_end: assert property (@(posedge clk_in) disable iff (rst_in)
    seq_quiet ##0 (s_r.state == adcseq_pkg::ST_CAL) && s_r.internal && (s_r.cnt == CAL_LAST)
    |=> conversion_strobe_out && (s_r.state == adcseq_pkg::ST_IDLE))
    else $error("internal calibration end not marked");

  a_cal_abort: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_r.state == adcseq_pkg::ST_CAL) && (!shutdown_n_s || !hrst_s) |=> !calibrating_out)
    else $error("calibration not aborted");

  a_range_switch: assert property (@(posedge clk_in) disable iff (rst_in)
    seq_quiet ##0 recv && (bit_new == IDX_POL) |=> s_r.unipolar == $past(din_s))
    else $error("range not switched at once");

  a_start_acq: assert property (@(posedge clk_in) disable iff (rst_in)
    hrst_s && shutdown_n_s && start_ok
    |=> acquire_out && (s_r.fall_cnt == 6'h00) && $stable(s_r.unipolar))
    else $error("start bit did not begin acquisition");

  a_sample_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(s_r.acquire) && converting_out
    |-> (s_r.fall_cnt == FALL_SHORT) || (s_r.fall_cnt == FALL_LONG))
    else $error("sampling ended on wrong edge");

  a_acq_length: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(s_r.acquire) && converting_out
    |-> s_r.acq_len == (((s_r.fall_cnt == FALL_LONG) ? HALF_LONG : HALF_SHORT) -
                        (s_r.changed ? HALF_PENALTY : 5'h00)))
    else $error("acquisition length wrong");

  a_clock_source: assert property (@(posedge clk_in) disable iff (rst_in)
    seq_quiet ##0 byte_done |=> clock_source_select_out == $past(s_r.clk_bit))
    else $error("clock source not taken from control byte");

  a_soft_down: assert property (@(posedge clk_in) disable iff (rst_in)
    seq_quiet ##0 conv_done && (s_r.mode == adcseq_pkg::MODE_SHUTDOWN_N) |=> ##1 powered_down_out)
    else $error("software power-down not entered");

endmodule : adcseq_core

// File: verification/adcseq_host_model.sv
/*
  Serial host model: drives chip select, serial clock and data in, and reads
  data out in the same frame.
  Assumes clk_in is the 10 MHz system clock; one serial clock lasts 8 of them.
*/
`timescale 1ns/1ns
module adcseq_host_model (
  input wire logic clk_in,
  input wire logic dout_in,
  input wire logic dout_oe_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  logic last_bit;

  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
    last_bit = 1'b0;
  end

  // Shifts n bits MSB first; the serial clock stands still outside frames
  task automatic xfer(input int n, input logic [63:0] tx, input logic release_cs,
                      output logic [63:0] rx);
    rx = '0;
    if (cs_n_out !== 1'b0)
    begin
      cs_n_out <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
    for (int i = n - 1; i >= 0; i--)
    begin
      din_out <= tx[i];
      last_bit = tx[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      @(posedge clk_in);
      rx[i] = dout_in & dout_oe_in;
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    if (release_cs)
    begin
      cs_n_out <= 1'b1;
      din_out <= ~last_bit;
      repeat (8) @(posedge clk_in);
    end
  endtask : xfer
endmodule : adcseq_host_model

// File: verification/test_adcseq_core.sv
/*
  Self-checking testbench of the converter sequencer with a serial host model.
  Assumes a 10 MHz clock and shortened calibration and conversion counts.
*/
`timescale 1ns/1ns
module test_adcseq_core;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic shutdown_n_in = 1'b1;
  logic hard_reset_n_in = 1'b1;
  logic [15:0] result_in = 16'ha53c;
  logic sclk, cs_n, din, dout, dout_oe, strobe, strobe_oe, pol, clksrc, acquire, pd, cal, conv;
  logic [2:0] user;
  logic [4:0] acq_len;
  logic acq_prev = 1'b0;
  logic [2:0] user_d = 3'h0;
  logic acq_at_user = 1'b1;
  logic [63:0] rx;
  int acq_cnt = 0;
  int short_cnt = 0;
  int failures = 0;
  int comparisons = 0;

  always #50 clk_in = ~clk_in;

  adcseq_core #(.CAL_CYCLES(50), .CONV_CYCLES(40)) i_adcseq_core (
    .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
    .shutdown_n_in(shutdown_n_in), .hard_reset_n_in(hard_reset_n_in),
    .result_in(result_in), .dout_out(dout), .dout_oe_out(dout_oe),
    .conversion_strobe_out(strobe), .conversion_strobe_oe_out(strobe_oe),
    .user_out(user), .input_polarity_select_out(pol), .clock_source_select_out(clksrc),
    .acquire_out(acquire), .acq_len_out(acq_len), .powered_down_out(pd),
    .calibrating_out(cal), .converting_out(conv)
  );

  adcseq_host_model i_adcseq_host_model (
    .clk_in(clk_in), .dout_in(dout), .dout_oe_in(dout_oe),
    .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din)
  );

  // Length of the latest acquisition in system clocks
  always @(posedge clk_in)
  begin
    acq_prev <= acquire;
    user_d <= user;
    if (user !== user_d)
      acq_at_user <= acquire;
    if (acquire === 1'b1)
      acq_cnt <= (acq_prev === 1'b1) ? acq_cnt + 1 : 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic test_short;
    i_adcseq_host_model.xfer(24, 64'h0000_0000_00c5_0000, 1'b0, rx);
    repeat (4) @(posedge clk_in);
    chk(pol, 1'b1, "polarity unipolar");
    chk(clksrc, 1'b0, "clock source external");
    chk(user, 3'h5, "user bits");
    chk(acq_at_user, 1'b0, "channel switch after acquisition");
    chk(acq_len, 5'h07, "acquisition after range change");
    chk(conv, 1'b0, "short period end");
    short_cnt = acq_cnt;
    i_adcseq_host_model.xfer(16, 64'h0, 1'b0, rx);
    chk(rx[15:0], 16'ha53c, "short result");
  endtask : test_short

  task automatic test_long;
    result_in <= 16'h5ac3;
    i_adcseq_host_model.xfer(32, 64'h0000_0000_da00_0000, 1'b0, rx);
    repeat (4) @(posedge clk_in);
    chk(acq_len, 5'h1a, "long acquisition");
    chk(acq_cnt - short_cnt, 32'h0000_0040, "eight extra clocks");
    chk(conv, 1'b0, "long period end");
    chk(user, 3'h2, "user bits");
    i_adcseq_host_model.xfer(16, 64'h0, 1'b0, rx);
    chk(rx[15:0], 16'h5ac3, "long result");
  endtask : test_long

  task automatic test_soft_down;
    i_adcseq_host_model.xfer(32, 64'h0000_0000_d000_0000, 1'b0, rx);
    repeat (4) @(posedge clk_in);
    chk(pd, 1'b1, "software power-down");
    chk(acq_len, 5'h1a, "previous acquisition kept");
  endtask : test_soft_down

  task automatic test_cal_int;
    int n;
    n = 0;
    i_adcseq_host_model.xfer(8, 64'h0000_0000_0000_00a8, 1'b0, rx);
    chk(pd, 1'b0, "woken by start bit");
    chk(cal, 1'b1, "calibration running");
    chk(strobe, 1'b0, "internal strobe low");
    while (cal === 1'b1 && n < 80)
    begin
      @(posedge clk_in);
      n++;
    end
    chk(n >= 35 && n <= 50, 1'b1, "calibration length");
    @(posedge clk_in);
    chk(strobe, 1'b1, "internal strobe high");
    i_adcseq_host_model.xfer(8, 64'h0000_0000_0000_00a0, 1'b0, rx);
    chk(conv, 1'b1, "internal conversion running");
    chk(acq_len, 5'h0a, "acquisition in same range");
    repeat (32) @(posedge clk_in);
    chk(conv, 1'b0, "internal conversion done");
    chk(strobe, 1'b1, "internal conversion strobe");
    i_adcseq_host_model.xfer(16, 64'h0, 1'b0, rx);
    chk(rx[15:0], 16'h5ac3, "internal result");
  endtask : test_cal_int

  task automatic test_cal_ext;
    i_adcseq_host_model.xfer(8, 64'h0000_0000_0000_0088, 1'b0, rx);
    chk(cal, 1'b1, "calibration running");
    chk(strobe, 1'b1, "external strobe high");
    chk(strobe_oe, 1'b1, "strobe driven");
    i_adcseq_host_model.xfer(44, 64'h0, 1'b0, rx);
    chk(cal, 1'b1, "still calibrating");
    i_adcseq_host_model.xfer(10, 64'h0, 1'b0, rx);
    chk(cal, 1'b0, "calibration done");
    chk(strobe, 1'b0, "external strobe low");
  endtask : test_cal_ext

  task automatic test_abort;
    i_adcseq_host_model.xfer(8, 64'h0000_0000_0000_00a9, 1'b0, rx);
    chk(user, 3'h1, "user bits");
    chk(cal, 1'b1, "calibration running");
    shutdown_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(cal, 1'b0, "shutdown abort");
    chk(pd, 1'b1, "shutdown power-down");
    shutdown_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    i_adcseq_host_model.xfer(8, 64'h0000_0000_0000_00a9, 1'b0, rx);
    hard_reset_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(cal, 1'b0, "reset abort");
    chk(user, 3'h0, "user cleared");
    chk(clksrc, 1'b1, "internal clock after reset");
    chk(strobe, 1'b1, "strobe idle");
    hard_reset_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask : test_abort

  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(clksrc, 1'b1, "clock source reset");
    chk(pol, 1'b0, "bipolar after reset");
    test_short();
    test_long();
    test_soft_down();
    test_cal_int();
    test_cal_ext();
    test_abort();
    stop_test();
  end

  // Whole run needs about 2000 clocks
  initial
  begin
    repeat (20000) @(posedge clk_in);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : test_adcseq_core
